// ### shared/tmr_regs.svh
// Register offsets, field positions and power-on values of the bank
// How it works
// - Mirror addresses share the primary storage
// - Reserved gaps read zero, writes ignored
// - Local temperature: read-only signed byte
// - Fraction bits 4..3 masked unless filter or enhanced fraction on
// - One-shot write starts conversion only in standby, reads zero
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

`define TMR_A_LOCAL_TEMP 8'h00
`define TMR_A_RMT_HIGH 8'h01
`define TMR_A_ALERT_STAT 8'h02
`define TMR_A_CONFIG 8'h03
`define TMR_A_CONV_RATE 8'h04
`define TMR_A_LOCAL_HLIM 8'h05
`define TMR_A_RHLIM_UP 8'h07
`define TMR_A_RLLIM_UP 8'h08
`define TMR_A_CONFIG_M 8'h09
`define TMR_A_CONV_RATE_M 8'h0a
`define TMR_A_LOCAL_HLIM_M 8'h0b
`define TMR_A_RHLIM_UP_M 8'h0d
`define TMR_A_RLLIM_UP_M 8'h0e
`define TMR_A_ONE_SHOT 8'h0f
`define TMR_A_RMT_FRAC 8'h10
`define TMR_A_OFS_UP 8'h11
`define TMR_A_OFS_FRAC 8'h12
`define TMR_A_RHLIM_FRAC 8'h13
`define TMR_A_RLLIM_FRAC 8'h14
`define TMR_A_ALERT_MASK 8'h16
`define TMR_A_CRIT_LIM 8'h19
`define TMR_A_CRIT_HYST 8'h21
`define TMR_A_RSVD_ZERO 8'h30
`define TMR_A_RMT_U_HIGH 8'h31
`define TMR_A_RMT_U_FRAC 8'h32
`define TMR_A_POR_STAT 8'h33

`define TMR_R_CONFIG 8'h00
`define TMR_R_CONV_RATE 8'h80
`define TMR_R_LOCAL_HLIM 8'h46
`define TMR_R_RHLIM_UP 8'h69
`define TMR_R_RLLIM_UP 8'h00
`define TMR_R_OFS 8'h00
`define TMR_R_LIM_FRAC 8'h00
`define TMR_R_ALERT_MASK 8'ha4
`define TMR_R_CRIT_LIM 8'h6e
`define TMR_R_CRIT_HYST 8'h0a

// Writable bits of partially populated registers, and alert-mask bits forced high
`define TMR_M_CONFIG 8'he7
`define TMR_M_CONV_RATE 8'h0f
`define TMR_M_FRAC3 8'he0
`define TMR_M_ALERT_MASK 8'h5b
`define TMR_M_ALERT_ONES 8'ha4
`define TMR_M_CRIT_HYST 8'h7f

// Fraction masks: filter or enhanced fraction on keeps 5 bits, both off keep 3
`define TMR_M_FRAC_FULL 8'hf8
`define TMR_M_FRAC_NOFILT 8'he0
// Standby bit of configuration
`define TMR_B_STANDBY 6

`endif

// ### shared/tmr_pkg.sv
// Types shared by the thermal monitor register bank
package tmr_pkg;
   typedef struct packed {
      logic [7:0] local_reading_bits;
      logic [7:0] remote_reading_high;
      logic [7:0] remote_reading_frac;
      logic [7:0] remote_unsigned_high;
      logic [7:0] remote_unsigned_frac;
      logic [7:0] alert_status;
      logic [7:0] power_on_status;
   } tmr_meas_t;

   typedef struct packed {
      logic [7:0] configuration;
      logic [7:0] conversion_rate;
      logic [7:0] local_high_limit;
      logic [7:0] remote_high_limit_upper;
      logic [7:0] remote_low_limit_upper;
      logic [7:0] remote_offset_upper;
      logic [7:0] remote_offset_fraction;
      logic [7:0] remote_high_limit_fraction;
      logic [7:0] remote_low_limit_fraction;
      logic [7:0] alert_mask;
      logic [7:0] remote_critical_limit;
      logic [7:0] remote_critical_hysteresis;
   } tmr_ctrl_t;
endpackage

// ### design/tmr_bank.sv
// Byte-wide register bank of the remote-diode temperature monitor
`timescale 1ns/1ps
`include "tmr_regs.svh"

module tmr_bank
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port from the serial interface engine
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Measurement results from the conversion logic
   input wire tmr_pkg::tmr_meas_t meas,
   input wire logic remote_filter_on,
   input wire logic enhanced_fraction_enable,
   // Control to the conversion logic
   output tmr_pkg::tmr_ctrl_t ctrl,
   output logic one_shot_start
);

   tmr_pkg::tmr_ctrl_t next_ctrl;
   logic [7:0] next_rdata;
   logic next_one_shot;
   logic [7:0] frac_mask;

   // Mirror addresses fold onto their primary
   function automatic logic [7:0] fold_addr(input logic [7:0] a);
      logic [7:0] r;
      r = a;
      unique case (a)
         `TMR_A_CONFIG_M: r = `TMR_A_CONFIG;
         `TMR_A_CONV_RATE_M: r = `TMR_A_CONV_RATE;
         `TMR_A_LOCAL_HLIM_M: r = `TMR_A_LOCAL_HLIM;
         `TMR_A_RHLIM_UP_M: r = `TMR_A_RHLIM_UP;
         `TMR_A_RLLIM_UP_M: r = `TMR_A_RLLIM_UP;
         default: r = a;
      endcase
      return r;
   endfunction

   // Fraction bits below the filter's precision are forced low
   always_comb
   begin
      if (remote_filter_on || enhanced_fraction_enable)
         frac_mask = `TMR_M_FRAC_FULL;
      else
         frac_mask = `TMR_M_FRAC_NOFILT;
   end

   // ==========================================================
   // Write path
   always_comb
   begin
      next_ctrl = ctrl;
      next_one_shot = 1'b0;
      if (reg_wr)
      begin
         // Read-only and reserved addresses fall to default
         unique case (fold_addr(reg_addr))
            `TMR_A_CONFIG:
               next_ctrl.configuration = reg_wdata & `TMR_M_CONFIG;
            `TMR_A_CONV_RATE:
               next_ctrl.conversion_rate = reg_wdata & `TMR_M_CONV_RATE;
            `TMR_A_LOCAL_HLIM: next_ctrl.local_high_limit = reg_wdata;
            `TMR_A_RHLIM_UP:
               next_ctrl.remote_high_limit_upper = reg_wdata;
            `TMR_A_RLLIM_UP: next_ctrl.remote_low_limit_upper = reg_wdata;
            `TMR_A_ONE_SHOT:
               // Data discarded; only meaningful in standby
               next_one_shot =
                  ctrl.configuration[`TMR_B_STANDBY];
            `TMR_A_OFS_UP: next_ctrl.remote_offset_upper = reg_wdata;
            `TMR_A_OFS_FRAC:
               next_ctrl.remote_offset_fraction = reg_wdata & `TMR_M_FRAC3;
            `TMR_A_RHLIM_FRAC:
               next_ctrl.remote_high_limit_fraction =
                  reg_wdata & `TMR_M_FRAC3;
            `TMR_A_RLLIM_FRAC:
               next_ctrl.remote_low_limit_fraction =
                  reg_wdata & `TMR_M_FRAC3;
            `TMR_A_ALERT_MASK:
               next_ctrl.alert_mask = (reg_wdata & `TMR_M_ALERT_MASK)
                  | `TMR_M_ALERT_ONES;
            `TMR_A_CRIT_LIM: next_ctrl.remote_critical_limit = reg_wdata;
            `TMR_A_CRIT_HYST:
               next_ctrl.remote_critical_hysteresis =
                  reg_wdata & `TMR_M_CRIT_HYST;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Read path; data registered on the read strobe
   always_comb
   begin
      next_rdata = reg_rdata;
      if (reg_rd)
      begin
         unique case (fold_addr(reg_addr))
            `TMR_A_LOCAL_TEMP: next_rdata = meas.local_reading_bits;
            `TMR_A_RMT_HIGH: next_rdata = meas.remote_reading_high;
            `TMR_A_ALERT_STAT: next_rdata = meas.alert_status;
            `TMR_A_CONFIG: next_rdata = ctrl.configuration;
            `TMR_A_CONV_RATE: next_rdata = ctrl.conversion_rate;
            `TMR_A_LOCAL_HLIM: next_rdata = ctrl.local_high_limit;
            `TMR_A_RHLIM_UP: next_rdata = ctrl.remote_high_limit_upper;
            `TMR_A_RLLIM_UP: next_rdata = ctrl.remote_low_limit_upper;
            `TMR_A_ONE_SHOT: next_rdata = 8'h00;
            `TMR_A_RMT_FRAC:
               next_rdata = meas.remote_reading_frac & frac_mask;
            `TMR_A_OFS_UP: next_rdata = ctrl.remote_offset_upper;
            `TMR_A_OFS_FRAC: next_rdata = ctrl.remote_offset_fraction;
            `TMR_A_RHLIM_FRAC: next_rdata = ctrl.remote_high_limit_fraction;
            `TMR_A_RLLIM_FRAC: next_rdata = ctrl.remote_low_limit_fraction;
            `TMR_A_ALERT_MASK: next_rdata = ctrl.alert_mask;
            `TMR_A_CRIT_LIM: next_rdata = ctrl.remote_critical_limit;
            `TMR_A_CRIT_HYST: next_rdata = ctrl.remote_critical_hysteresis;
            `TMR_A_RMT_U_HIGH: next_rdata = meas.remote_unsigned_high;
            `TMR_A_RMT_U_FRAC:
               next_rdata = meas.remote_unsigned_frac & frac_mask;
            `TMR_A_POR_STAT: next_rdata = meas.power_on_status;
            // Gaps, including the zero register, read as zero
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // State registers
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl.configuration <= `TMR_R_CONFIG;
         ctrl.conversion_rate <= `TMR_R_CONV_RATE;
         ctrl.local_high_limit <= `TMR_R_LOCAL_HLIM;
         ctrl.remote_high_limit_upper <= `TMR_R_RHLIM_UP;
         ctrl.remote_low_limit_upper <= `TMR_R_RLLIM_UP;
         ctrl.remote_offset_upper <= `TMR_R_OFS;
         ctrl.remote_offset_fraction <= `TMR_R_OFS;
         ctrl.remote_high_limit_fraction <= `TMR_R_LIM_FRAC;
         ctrl.remote_low_limit_fraction <= `TMR_R_LIM_FRAC;
         ctrl.alert_mask <= `TMR_R_ALERT_MASK;
         ctrl.remote_critical_limit <= `TMR_R_CRIT_LIM;
         ctrl.remote_critical_hysteresis <= `TMR_R_CRIT_HYST;
         reg_rdata <= 8'h00;
         one_shot_start <= 1'b0;
      end
      else
      begin
         ctrl <= next_ctrl;
         reg_rdata <= next_rdata;
         one_shot_start <= next_one_shot;
      end
   end

endmodule

// ### dv/tmr_bank_monitor.sv
// Port-level checks of the register bank
`timescale 1ns/1ps
module tmr_bank_monitor
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Conversion side
   input wire tmr_pkg::tmr_meas_t meas,
   input wire logic remote_filter_on,
   input wire logic enhanced_fraction_enable,
   input wire tmr_pkg::tmr_ctrl_t ctrl,
   input wire logic one_shot_start
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_mirror_write: assert property (
      reg_wr && reg_addr == 8'h0b |=> ctrl.local_high_limit == $past(reg_wdata))
      else $error("mirror write lost");
   a_rsvd_zero: assert property (
      reg_rd && reg_addr inside {8'h06, 8'h0c, 8'h30} |=> reg_rdata == 8'h00)
      else $error("reserved read not zero");
   a_local_read: assert property (
      reg_rd && reg_addr == 8'h00 |=> reg_rdata == $past(meas[55:48]))
      else $error("local reading wrong");
   a_frac_nofilt: assert property (
      reg_rd && reg_addr == 8'h10 && !remote_filter_on
      && !enhanced_fraction_enable |=> reg_rdata[4:0] == 5'h00)
      else $error("fraction not masked");
   a_start_standby: assert property (
      reg_wr && reg_addr == 8'h0f && ctrl.configuration[6] |=> one_shot_start)
      else $error("one-shot start missing");
   a_no_stray_start: assert property (
      !(reg_wr && reg_addr == 8'h0f) |=> !one_shot_start)
      else $error("stray one-shot start");
   a_oneshot_zero: assert property (
      reg_rd && reg_addr == 8'h0f |=> reg_rdata == 8'h00)
      else $error("one-shot read not zero");
   a_ro_write: assert property (
      reg_wr && reg_addr == 8'h00 |=> $stable(ctrl))
      else $error("read-only write changed control");
endmodule
bind tmr_bank tmr_bank_monitor tmr_bank_monitor_i (.*);

// ### dv/tmr_host.sv
// Host model issuing single-byte register accesses
`timescale 1ns/1ps
module tmr_host
(
   // Clock
   input wire logic core_clk,
   // Strobes toward the bank
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd
);
   initial
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
   // Callers pass only defined addresses
   task automatic acc(input logic w, input logic [7:0] a, d);
      @(posedge core_clk);
      {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
      @(posedge core_clk);
      // Released lines carry junk, not the last byte
      {reg_addr, reg_wdata, reg_wr, reg_rd} <= {~a, ~d, 2'b00};
   endtask
endmodule

// ### dv/tb.sv
// Self-checking bench of the register bank
`timescale 1ns/1ps
module tb;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, r;
   logic reg_wr, reg_rd, one_shot_start, rd_d = 1'b0;
   logic remote_filter_on = 1'b0;
   logic enhanced_fraction_enable = 1'b0;
   logic [63:0] rnd;
   tmr_pkg::tmr_meas_t meas = '0;
   tmr_pkg::tmr_ctrl_t ctrl;
   int fail_count = 0, n_compared = 0, n_pulse = 0, cyc = 0;
   logic [7:0] exp_q[$];
   logic [15:0] por[12] = '{16'h0300, 16'h0480, 16'h0546, 16'h0769,
      16'h0800, 16'h1100, 16'h1200, 16'h1300, 16'h1400, 16'h16a4,
      16'h196e, 16'h210a};
   tmr_bank tmr_bank_i (.*);
   tmr_host tmr_host_i (.*);
   initial
      forever #25 core_clk = ~core_clk;
   task automatic chk(input logic [7:0] got, exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, e);
      exp_q.push_back(e);
      tmr_host_i.acc(1'b0, a, 8'h00);
   endtask
   task end_of_test;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Read data is settled half a cycle after the strobe edge
   always @(negedge core_clk)
      if (rd_d === 1'b1)
         chk(reg_rdata, exp_q.pop_front());
   always @(posedge core_clk)
   begin
      rd_d <= reg_rd;
      cyc++;
      if (one_shot_start === 1'b1)
         n_pulse++;
      if (cyc == 1000)
      begin
         fail_count++;
         end_of_test();
      end
   end
   initial
   begin
      void'($urandom(96882));
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (por[i])
         rd(por[i][15:8], por[i][7:0]);
      $display("test done: power-on values");
      r = $urandom;
      tmr_host_i.acc(1'b1, 8'h0b, r);
      rd(8'h05, r);
      tmr_host_i.acc(1'b1, 8'h07, ~r);
      rd(8'h0d, ~r);
      $display("test done: mirrors");
      rnd = {$urandom, $urandom};
      meas <= rnd[55:0];
      tmr_host_i.acc(1'b1, 8'h00, ~rnd[55:48]);
      rd(8'h00, rnd[55:48]);
      rd(8'h30, 8'h00);
      rd(8'h0f, 8'h00);
      tmr_host_i.acc(1'b1, 8'h01, ~rnd[47:40]);
      rd(8'h01, rnd[47:40]);
      tmr_host_i.acc(1'b1, 8'h31, ~rnd[31:24]);
      rd(8'h31, rnd[31:24]);
      rd(8'h02, rnd[15:8]);
      rd(8'h33, rnd[7:0]);
      // Partly populated registers keep only their live bits
      tmr_host_i.acc(1'b1, 8'h0a, 8'hff);
      rd(8'h04, 8'h0f);
      tmr_host_i.acc(1'b1, 8'h16, 8'h00);
      rd(8'h16, 8'ha4);
      tmr_host_i.acc(1'b1, 8'h21, 8'hff);
      rd(8'h21, 8'h7f);
      tmr_host_i.acc(1'b1, 8'h12, 8'hff);
      rd(8'h12, 8'he0);
      for (int k = 0; k < 4; k++)
      begin
         {remote_filter_on, enhanced_fraction_enable} <= 2'(k);
         rd(8'h10, rnd[39:32] & (k != 0 ? 8'hf8 : 8'he0));
         rd(8'h32, rnd[23:16] & (k != 0 ? 8'hf8 : 8'he0));
      end
      $display("test done: read-only and fraction");
      tmr_host_i.acc(1'b1, 8'h0f, r);
      tmr_host_i.acc(1'b1, 8'h09, 8'h40);
      rd(8'h03, 8'h40);
      tmr_host_i.acc(1'b1, 8'h0f, r);
      repeat (2) @(posedge core_clk);
      chk(8'(n_pulse), 8'h01);
      $display("test done: one-shot");
      // Reset in mid-run must restore every writable register
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (por[i])
         rd(por[i][15:8], por[i][7:0]);
      $display("test done: second reset");
      end_of_test();
   end
endmodule
